// ### design/xoc_osc_control.sv
// control register, state sequencing and clock gating of the crystal oscillator
// Overview of operation
// - bit 7 enables the peripheral reference clock output.
// - bit 5 keeps reference clock running in stop if enable already set.
// - bits 6 and 4 are reserved, read-only, read as zero.
// - bits 3..0 each switch in a 2, 4, 8 or 16 pF load capacitor.
// - enabled with internal oscillator selected enters startup with output gated off.
// - startup counts 4096 raw oscillator cycles then declares stable and passes clock.
// - stable state holds while enabled, internal selected and count done.
// - enabled with internal select clear buffers input pin straight to output.
// - off state decouples both pins and holds oscillator clock static unless internal select is clear.
// - startup counter clears whenever clocks are not requested.
// - in stop the oscillator runs only if both enable bits set.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`include "xoc_regs.svh"
module xoc_osc_control #(
    parameter int STARTUP_COUNT = `XOC_STARTUP_COUNT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic osc_enable,
    input wire logic internal_osc_select,
    input wire logic stop_mode,
    input wire logic osc_input_pin,
    input wire logic amp_ok,
    output logic osc_output_pin_o,
    output logic osc_output_pin_oe_n,
    output logic osc_clk_out,
    output logic peripheral_ref_clock,
    output logic osc_pins_coupled,
    output logic osc_running,
    output logic [3:0] load_cap_sel
);
    import xoc_pkg::*;

    xoc_ctrl_t ctrl_ff;
    xoc_ctrl_t nxt_ctrl;
    logic ack_ff;
    logic nxt_ack;
    logic err_ff;
    logic nxt_err;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;
    xoc_state_e state_ff;
    xoc_state_e nxt_state;
    logic raw_prev_ff;
    logic nxt_raw_prev;
    logic clk_out_ff;
    logic nxt_clk_out;
    logic ref_ff;
    logic nxt_ref;
    logic xout_ff;
    logic nxt_xout;
    logic req;
    logic hit_ctrl;
    logic hit_stat;
    logic raw_osc_clock;
    logic raw_tick;
    logic startup_count_done;
    logic ref_clock_enable;
    logic ref_clock_stop_enable;
    logic run_req;

    assign ref_clock_enable = ctrl_ff[`XOC_BIT_REF_EN];
    assign ref_clock_stop_enable = ctrl_ff[`XOC_BIT_STOP_EN];
    // in stop the chip drops its request; the oscillator survives only if both bits set
    assign run_req = stop_mode ? (ref_clock_enable && ref_clock_stop_enable)
                               : osc_enable;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_ctrl = wb_adr_i == `XOC_CTRL_OFFSET;
    assign hit_stat = wb_adr_i == `XOC_STATUS_OFFSET;

    // register bus: one registered answer per request, one clock later; error on unmapped address
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_ack = 1'b0;
        nxt_err = 1'b0;
        nxt_rdat = rdat_ff;
        if (req) begin
            nxt_ack = hit_ctrl || hit_stat;
            nxt_err = !(hit_ctrl || hit_stat);
            nxt_rdat = 32'h0000_0000;
            if (hit_ctrl) begin
                if (wb_we_i && wb_sel_i[0]) begin
                    // reserved bits 6 and 4 never store
                    nxt_ctrl = wb_dat_i[7:0] & `XOC_CTRL_WMASK;
                end
                nxt_rdat = {24'h00_0000, ctrl_ff & `XOC_CTRL_WMASK};
            end else if (hit_stat) begin
                nxt_rdat = {26'h000_0000, startup_count_done, raw_osc_clock,
                            2'(state_ff), osc_clk_out, peripheral_ref_clock};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_ff <= `XOC_CTRL_RESET;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdat_ff;

    // off: pins decoupled; raw clock static unless the external input is chosen
    assign osc_pins_coupled = (state_ff != XOC_OFF);
    assign raw_osc_clock = (state_ff == XOC_OFF) ? (!internal_osc_select && osc_input_pin)
                                                 : (osc_input_pin && amp_ok);
    assign raw_tick = raw_osc_clock && !raw_prev_ff;

    xoc_startup_counter #(
        .COUNT(STARTUP_COUNT)
    ) u_counter (
        .clk(clk),
        .nrst(nrst),
        // kept through stable so the done indication stands while the clock is passed
        .clear(state_ff != XOC_STARTUP && state_ff != XOC_STABLE),
        .tick(raw_tick),
        .done(startup_count_done)
    );

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            XOC_OFF: begin
                if (run_req && internal_osc_select) begin
                    nxt_state = XOC_STARTUP;
                end else if (run_req) begin
                    nxt_state = XOC_EXTCLK;
                end
            end
            XOC_STARTUP: begin
                if (!run_req || !internal_osc_select) begin
                    nxt_state = XOC_OFF;
                end else if (startup_count_done) begin
                    nxt_state = XOC_STABLE;
                end
            end
            XOC_STABLE: begin
                // leaves only when the request or selection drops
                if (!run_req || !internal_osc_select) begin
                    nxt_state = XOC_OFF;
                end
            end
            XOC_EXTCLK: begin
                if (!run_req || internal_osc_select) begin
                    nxt_state = XOC_OFF;
                end
            end
            default: nxt_state = XOC_OFF;
        endcase
    end

    always_comb begin
        nxt_raw_prev = raw_osc_clock;
        nxt_clk_out = 1'b0;
        nxt_xout = 1'b0;
        case (state_ff)
            XOC_STABLE: nxt_clk_out = raw_osc_clock;
            XOC_EXTCLK: nxt_clk_out = osc_input_pin;
            default: nxt_clk_out = 1'b0;
        endcase
        if (state_ff == XOC_STARTUP || state_ff == XOC_STABLE) begin
            nxt_xout = !osc_input_pin;
        end
        // gated copy for peripherals; in stop passed only while the stop enable bit is set
        nxt_ref = ref_clock_enable && nxt_clk_out
                  && (!stop_mode || ref_clock_stop_enable);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= XOC_OFF;
            raw_prev_ff <= 1'b0;
            clk_out_ff <= 1'b0;
            ref_ff <= 1'b0;
            xout_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            raw_prev_ff <= nxt_raw_prev;
            clk_out_ff <= nxt_clk_out;
            ref_ff <= nxt_ref;
            xout_ff <= nxt_xout;
        end
    end

    assign osc_clk_out = clk_out_ff;
    assign peripheral_ref_clock = ref_ff;
    assign osc_output_pin_o = xout_ff;
    // output pin only driven by the amplifier; external mode leaves it free for other use
    assign osc_output_pin_oe_n = !(state_ff == XOC_STARTUP || state_ff == XOC_STABLE);
    assign osc_running = (state_ff != XOC_OFF);
    assign load_cap_sel = {ctrl_ff[`XOC_BIT_CAP16], ctrl_ff[`XOC_BIT_CAP8],
                           ctrl_ff[`XOC_BIT_CAP4], ctrl_ff[`XOC_BIT_CAP2]};
endmodule

// ### common/xoc_regs.svh
// register offsets, field positions, reset values and timing counts of the oscillator control
`ifndef XOC_REGS_SVH
`define XOC_REGS_SVH
`define XOC_CTRL_OFFSET 32'h4006_5000
`define XOC_STATUS_OFFSET 32'h4006_5004
`define XOC_CTRL_RESET 8'h00
`define XOC_CTRL_WMASK 8'hAF
`define XOC_BIT_REF_EN 7
`define XOC_BIT_STOP_EN 5
`define XOC_BIT_CAP2 3
`define XOC_BIT_CAP4 2
`define XOC_BIT_CAP8 1
`define XOC_BIT_CAP16 0
`define XOC_STARTUP_COUNT 4096
`endif

// ### common/xoc_pkg.sv
// types of the oscillator control
package xoc_pkg;
    typedef enum logic [1:0] {
        XOC_OFF,
        XOC_STARTUP,
        XOC_STABLE,
        XOC_EXTCLK
    } xoc_state_e;
    typedef logic [7:0] xoc_ctrl_t;
endpackage

// ### design/xoc_startup_counter.sv
// startup cycle counter clocked by clk, counting rising edges of the raw oscillator samples
`timescale 1ns/10ps
module xoc_startup_counter #(
    parameter int COUNT = 4096
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic tick,
    output logic done
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_done = done_ff;
        if (clear) begin
            nxt_cnt = '0;
            nxt_done = 1'b0;
        end else if (tick && !done_ff) begin
            nxt_cnt = cnt_ff + W'(1);
            nxt_done = (cnt_ff == W'(COUNT - 1));
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign done = done_ff;
endmodule

// ### bench/xoc_osc_output_pin_model.sv
// behavioural crystal or driven clock on the oscillator pins
`timescale 1ns/10ps
module xoc_osc_output_pin_model (
    input wire logic clk,
    input wire logic drive_n,
    input wire logic bypass,
    output logic pin,
    output logic amp_ok
);
    logic [3:0] age = 4'h0;
    initial pin = 1'b0;
    initial amp_ok = 1'b0;
    always @(posedge clk) begin
        if (bypass) begin
            pin <= ~pin;
        end else if (!drive_n) begin
            // amplitude needs a few swings before the buffer passes it
            age <= (age == 4'hF) ? age : age + 4'h1;
            amp_ok <= (age > 4'h5);
            pin <= ~pin;
        end else begin
            // undriven crystal dies out, no swing left on the pin
            age <= 4'h0;
            amp_ok <= 1'b0;
            pin <= 1'b0;
        end
    end
endmodule

// ### bench/xoc_osc_control_asserts.sv
// port assertions of the oscillator control
`timescale 1ns/10ps
`include "xoc_regs.svh"
module xoc_osc_control_asserts #(
    parameter int STARTUP_COUNT = 4096
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic internal_osc_select,
    input wire logic stop_mode,
    input wire logic osc_input_pin,
    input wire logic amp_ok,
    input wire logic osc_output_pin_oe_n,
    input wire logic osc_clk_out,
    input wire logic peripheral_ref_clock,
    input wire logic osc_pins_coupled,
    input wire logic [3:0] load_cap_sel
);
    logic [15:0] cnt_ff, nxt_cnt;
    logic edge_ff, nxt_edge, ref_ff, nxt_ref, stp_ff, nxt_stp, wr;
    assign wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `XOC_CTRL_OFFSET;
    // own edge count runs in step with the design's counter and keeps counting past done, so bounds stay safe
    always_comb begin
        nxt_edge = osc_input_pin && amp_ok;
        nxt_ref = wr ? wb_dat_i[7] : ref_ff;
        nxt_stp = wr ? wb_dat_i[5] : stp_ff;
        nxt_cnt = cnt_ff;
        if (!osc_pins_coupled || !internal_osc_select) nxt_cnt = 16'h0000;
        else if (nxt_edge && !edge_ff && cnt_ff != 16'hFFFF) nxt_cnt = cnt_ff + 16'h0001;
    end
    always_ff @(posedge clk) begin
        cnt_ff <= nrst ? nxt_cnt : 16'h0000;
        edge_ff <= nrst && nxt_edge;
        ref_ff <= nrst && nxt_ref;
        stp_ff <= nrst && nxt_stp;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence start_s;
        $rose(osc_pins_coupled) && internal_osc_select;
    endsequence
    property cap_p;
        wr |-> ##[0:1] load_cap_sel == {wb_dat_i[0], wb_dat_i[1], wb_dat_i[2], wb_dat_i[3]};
    endproperty
    a_rsvd_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `XOC_CTRL_OFFSET
        |-> (wb_dat_o & 32'hFFFF_FF50) == 32'h0000_0000) else $error("reserved bits read set");
    a_cap_map: assert property (cap_p) else $error("load select differs");
    a_ref_gate: assert property (!ref_ff [*3] |-> !peripheral_ref_clock)
        else $error("reference clock while disabled");
    a_stop_gate: assert property ((stop_mode && !stp_ff) [*3] |-> !peripheral_ref_clock)
        else $error("reference clock in stop");
    a_startup_gated: assert property (start_s |-> !osc_clk_out [*8])
        else $error("output clock during startup");
    // pin driven marks startup or stable; a bypass clock still draining is left out
    a_count_reached: assert property (osc_clk_out && internal_osc_select && !osc_output_pin_oe_n
        |-> cnt_ff >= 16'(STARTUP_COUNT)) else $error("output clock before full count");
    a_stable_runs: assert property (osc_pins_coupled && internal_osc_select && nxt_edge
        && !edge_ff && cnt_ff > 16'(STARTUP_COUNT + 1) |-> ##[1:3] osc_clk_out)
        else $error("stable clock missing");
    a_ext_buffer: assert property (osc_pins_coupled && osc_output_pin_oe_n
        && !internal_osc_select && $rose(osc_input_pin) |-> ##[1:3] osc_clk_out)
        else $error("bypass clock missing");
    a_off_decoupled: assert property (!osc_pins_coupled |-> osc_output_pin_oe_n)
        else $error("pin driven while off");
endmodule
bind xoc_osc_control xoc_osc_control_asserts #(
    .STARTUP_COUNT(STARTUP_COUNT)
) i_chk (
    .clk(clk),
    .nrst(nrst),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .internal_osc_select(internal_osc_select),
    .stop_mode(stop_mode),
    .osc_input_pin(osc_input_pin),
    .amp_ok(amp_ok),
    .osc_output_pin_oe_n(osc_output_pin_oe_n),
    .osc_clk_out(osc_clk_out),
    .peripheral_ref_clock(peripheral_ref_clock),
    .osc_pins_coupled(osc_pins_coupled),
    .load_cap_sel(load_cap_sel)
);

// ### bench/testbench.sv
// self-checking bench of the oscillator control
`timescale 1ns/10ps
`include "xoc_regs.svh"
module testbench;
    localparam logic [31:0] C = `XOC_CTRL_OFFSET, S = `XOC_STATUS_OFFSET, M = 32'h0000_000C;
    logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, en = 1'b0, isel = 1'b1;
    logic stp = 1'b0, byp = 1'b0, ack, err, pin, amp, oe_n, clko, refc;
    logic [31:0] adr = 32'h0000_0000, wd = 32'h0000_0000, rd;
    logic [3:0] sel = 4'h0;
    logic [64:0] e;
    logic [64:0] q[$];
    int errors = 0, tests_run = 0;
    always #2 clk = ~clk;
    xoc_osc_control #(.STARTUP_COUNT(8)) i_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err), .osc_enable(en),
        .internal_osc_select(isel), .stop_mode(stp), .osc_input_pin(pin), .amp_ok(amp),
        .osc_output_pin_o(), .osc_output_pin_oe_n(oe_n), .osc_clk_out(clko),
        .peripheral_ref_clock(refc), .osc_pins_coupled(), .osc_running(), .load_cap_sel());
    xoc_osc_output_pin_model i_osc_output_pin (.clk(clk), .drive_n(oe_n), .bypass(byp), .pin(pin), .amp_ok(amp));
    task automatic check(input logic [31:0] got, exp, mask);
        tests_run++;
        if (((got ^ exp) & mask) !== 32'h0000_0000) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        if ((ack === 1'b1 && !we) || err === 1'b1) begin
            e = q.pop_front();
            check({31'h0, err}, {31'h0, e[64]}, 32'h0000_0001);
            check(rd, e[31:0], e[63:32]);
        end
    end
    task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] s,
        input logic [64:0] x);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        sel <= s;
        if (!w || x[64]) q.push_back(x);
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        cyc <= 1'b0;
        if (n >= 50) errors++;
    endtask
    task automatic rdx(input logic [31:0] a, m, d);
        bus(1'b0, a, 32'h0000_0000, 4'hF, {1'b0, m, d});
    endtask
    task automatic wait_clk(input logic pick);
        int n;
        n = 0;
        tests_run++;
        while ((pick ? refc : clko) !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) errors++;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #40000;
        errors++;
        end_of_test;
    end
    initial begin
        logic [7:0] v;
        void'($urandom(9));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rdx(C, 32'hFFFF_FFFF, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            bus(1'b1, C, {24'h0, v}, 4'h1, 65'h0);
            bus(1'b1, C, 32'h0000_00FF, 4'hE, 65'h0);
            rdx(C, 32'hFFFF_FFFF, {24'h0, v & 8'hAF});
        end
        bus(1'b0, C + 32'h0000_0008, 32'h0000_0000, 4'hF, {1'b1, 64'h0});
        bus(1'b1, C + 32'h0000_0008, 32'h0000_00FF, 4'hF, {1'b1, 64'h0});
        $display("test registers done");
        en <= 1'b1;
        rdx(S, M, 32'h0000_0004);
        wait_clk(1'b0);
        rdx(S, 32'h0000_002C, 32'h0000_0028);
        en <= 1'b0;
        rdx(S, M, 32'h0000_0000);
        en <= 1'b1;
        rdx(S, 32'h0000_002C, 32'h0000_0004);
        isel <= 1'b0;
        byp <= 1'b1;
        // startup drops to off first, one edge before bypass is entered
        @(posedge clk);
        rdx(S, M, 32'h0000_000C);
        wait_clk(1'b0);
        $display("test oscillator done");
        // whole control byte rewritten while clocks run; load capacitor bits go to zero
        bus(1'b1, C, 32'h0000_0080, 4'h1, 65'h0);
        wait_clk(1'b1);
        stp <= 1'b1;
        rdx(S, 32'h0000_000D, 32'h0000_0000);
        bus(1'b1, C, 32'h0000_00A0, 4'h1, 65'h0);
        rdx(S, M, 32'h0000_000C);
        wait_clk(1'b1);
        $display("test stop done");
        end_of_test;
    end
endmodule
